/* File: pbp_defines.svh */
`ifndef PBP_DEFINES_SVH
`define PBP_DEFINES_SVH
// ----------------------------------------
// program memory map
// ----------------------------------------
`define PBP_ADDR_W 22
`define PBP_BOOT_END 22'h0007ff
`define PBP_MEM_TOP 22'h200000
`define PBP_SMALL_KB 32
`define PBP_SMALL_LSB 13
`define PBP_LARGE_LSB 14
`define PBP_BLK_BOOT 3'h0
`define PBP_NBLK 5
// ----------------------------------------
// configuration bytes and identification
// ----------------------------------------
`define PBP_CFG_RP_LO 22'h300008
`define PBP_CFG_RP_HI 22'h300009
`define PBP_CFG_WP_LO 22'h30000a
`define PBP_CFG_WP_HI 22'h30000b
`define PBP_CFG_TRP_LO 22'h30000c
`define PBP_CFG_TRP_HI 22'h30000d
`define PBP_DEVID_LO 22'h3ffffe
`define PBP_DEVID_HI 22'h3fffff
`define PBP_BOOT_BIT 6
`define PBP_CFGWP_BIT 5
// ----------------------------------------
// reset values (erased state)
// ----------------------------------------
`define PBP_PROT_RST 5'h1f
`define PBP_CFGWP_RST 1'h1
`define PBP_ZERO_BYTE 8'h00
`endif

/* File: pbp_pkg.sv */
`default_nettype none
package pbp_pkg;
  // ----------------------------------------
  // shared types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_DONE = 3'b100
  } pbp_state_type;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_ERASE_ALL = 2'h2,
    OP_ERASE_BLK = 2'h3
  } pbp_op_type;

  typedef logic [2:0] pbp_blk_type;
endpackage
`default_nettype wire

/* File: pbp_blk_map.sv */
`include "pbp_defines.svh"
`default_nettype none
module pbp_blk_map #(
  parameter int MEM_KB = 64
) (
  input wire logic [21:0] i_addr,
  output var pbp_pkg::pbp_blk_type o_blk,
  output logic o_impl
);
  import pbp_pkg::*;

  localparam logic [22:0] LIMIT = 23'(MEM_KB * 1024);
  localparam bit SMALL = (MEM_KB <= `PBP_SMALL_KB);

  // ----------------------------------------
  // address to block index, boot block is 0
  // ----------------------------------------
  always_comb begin
    o_impl = ({1'b0, i_addr} < LIMIT);
    if (i_addr <= `PBP_BOOT_END) begin
      o_blk = `PBP_BLK_BOOT;
    end else if (SMALL) begin
      o_blk = 3'({1'b0, i_addr[`PBP_SMALL_LSB+1:`PBP_SMALL_LSB]}) + 3'h1;
    end else begin
      o_blk = 3'({1'b0, i_addr[`PBP_LARGE_LSB+1:`PBP_LARGE_LSB]}) + 3'h1;
    end
  end
endmodule
`default_nettype wire

/* File: pbp_prot_top.sv */
// Functional notes
// - program memory splits into a 2 Kbyte boot block and four binary blocks.
// - each of five blocks has its own read, write and table-read protect bit.
// - small parts: boot to 0007FFh, block 1 to 1FFFh, block 2 2000h-3FFFh, blocks 3,4 follow.
// - large parts: blocks 1-4 end 3FFFh, 7FFFh, BFFFh, FFFFh; 010000h up reads zero.
// - read-protect bits leave core access alone but block programmer reads and writes.
// - table read from inside a table-read-protected block returns true data.
// - table read from outside a table-read-protected block is refused, returns zero.
// - protection bits can be written only from one to zero; the programmer writes the config write-protect bit either way.
// - only reset, chip erase or block erase returns protection bits to one; a programmer write can also set the config write-protect bit.
// - chip and block erase are accepted only from the external programmer.
// - table reads and writes reach any program location, subject to protection.
// - the identification word is returned by table reads at its address.
// - configuration bytes are table readable and writable with the one-way restriction; the programmer writes the config write-protect bit either way.
// - configuration write-protect bit is writable only by the external programmer.
`include "pbp_defines.svh"
`default_nettype none
module pbp_prot_top #(
  parameter int MEM_KB = 64,
  parameter logic [7:0] DEV_ID_LO = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_ID_HI = 8'ha5 // arbitrary value
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_core_req,
  input wire pbp_pkg::pbp_op_type i_core_op,
  input wire logic [21:0] i_core_addr,
  input wire logic [21:0] i_core_pc,
  input wire logic [7:0] i_core_wdata,
  input wire logic i_prog_req,
  input wire pbp_pkg::pbp_op_type i_prog_op,
  input wire logic [21:0] i_prog_addr,
  input wire logic [7:0] i_prog_wdata,
  input wire logic [7:0] i_mem_rdata,
  output logic o_core_ack,
  output logic o_prog_ack,
  output logic [7:0] o_rdata,
  output logic o_refused,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic o_mem_erase_all,
  output logic o_mem_erase_blk,
  output logic [21:0] o_mem_addr,
  output logic [7:0] o_mem_wdata
);
  import pbp_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  pbp_state_type state_reg;
  logic [4:0] rp_reg;
  logic [4:0] wp_reg;
  logic [4:0] trp_reg;
  logic cfg_wp_reg;
  logic sel_prog_reg;

  // ----------------------------------------
  // request selection, programmer first
  // ----------------------------------------
  logic take;
  logic sel_prog;
  pbp_op_type act_op;
  logic [21:0] act_addr;
  logic [7:0] act_wdata;
  pbp_blk_type t_blk;
  pbp_blk_type pc_blk;
  logic t_impl;
  logic pc_impl;
  logic is_mem;
  logic is_cfg;
  logic rd_ok;
  logic wr_ok;
  logic cfg_wr_ok;
  logic erase_go;
  logic deny;
  logic [7:0] rd_byte;

  assign take = (state_reg == ST_IDLE) && (i_prog_req || i_core_req);
  assign sel_prog = i_prog_req;
  assign act_op = sel_prog ? i_prog_op : i_core_op;
  assign act_addr = sel_prog ? i_prog_addr : i_core_addr;
  assign act_wdata = sel_prog ? i_prog_wdata : i_core_wdata;

  // target block and block of the issuing instruction
  pbp_blk_map #(.MEM_KB(MEM_KB)) u_map_tgt (
    .i_addr(act_addr),
    .o_blk(t_blk),
    .o_impl(t_impl)
  );

  pbp_blk_map #(.MEM_KB(MEM_KB)) u_map_pc (
    .i_addr(i_core_pc),
    .o_blk(pc_blk),
    .o_impl(pc_impl)
  );

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // protection bits only ever drop on a write
  function automatic logic [4:0] one_way(input logic [4:0] old, input logic [4:0] wr);
    one_way = old & wr;
  endfunction

  // configuration byte image, reserved bits read zero
  function automatic logic [7:0] cfg_byte(input logic [21:0] a, input logic [4:0] rp,
                                          input logic [4:0] wp, input logic [4:0] trp,
                                          input logic cw);
    logic [7:0] b;
    b = `PBP_ZERO_BYTE;
    unique case (a)
      `PBP_CFG_RP_LO: b[3:0] = rp[4:1];
      `PBP_CFG_RP_HI: b[`PBP_BOOT_BIT] = rp[0];
      `PBP_CFG_WP_LO: b[3:0] = wp[4:1];
      `PBP_CFG_WP_HI: begin
        b[`PBP_BOOT_BIT] = wp[0];
        b[`PBP_CFGWP_BIT] = cw;
      end
      `PBP_CFG_TRP_LO: b[3:0] = trp[4:1];
      `PBP_CFG_TRP_HI: b[`PBP_BOOT_BIT] = trp[0];
      default: b = `PBP_ZERO_BYTE;
    endcase
    cfg_byte = b;
  endfunction

  // ----------------------------------------
  // access decisions
  // ----------------------------------------
  assign is_mem = (act_addr < `PBP_MEM_TOP);
  assign is_cfg = (act_addr >= `PBP_CFG_RP_LO) && (act_addr <= `PBP_CFG_TRP_HI);

  // core ignores read-protect; table-read bit checked by issuing block
  assign rd_ok = t_impl && (sel_prog ? rp_reg[t_blk] :
                 (trp_reg[t_blk] || (pc_impl && (pc_blk == t_blk))));

  // write-protected blocks keep their contents
  assign wr_ok = t_impl && wp_reg[t_blk] && (!sel_prog || rp_reg[t_blk]);

  // core writes to configuration bytes need the config write-protect open
  assign cfg_wr_ok = sel_prog || cfg_wp_reg;

  // erase is only accepted from the programmer
  assign erase_go = take && sel_prog &&
                    ((act_op == OP_ERASE_ALL) || (act_op == OP_ERASE_BLK));

  // protection refusals, unimplemented space is not a refusal
  always_comb begin
    deny = 1'b0;
    unique case (act_op)
      OP_READ: deny = is_mem && t_impl && !rd_ok;
      OP_WRITE: deny = (is_mem && t_impl && !wr_ok) || (is_cfg && !cfg_wr_ok);
      default: deny = !sel_prog;
    endcase
  end

  // immediate read data for non-memory reads
  always_comb begin
    if (is_cfg) begin
      rd_byte = cfg_byte(act_addr, rp_reg, wp_reg, trp_reg, cfg_wp_reg);
    end else if (act_addr == `PBP_DEVID_LO) begin
      rd_byte = DEV_ID_LO;
    end else if (act_addr == `PBP_DEVID_HI) begin
      rd_byte = DEV_ID_HI;
    end else begin
      rd_byte = `PBP_ZERO_BYTE;
    end
  end

  // ----------------------------------------
  // sequencer and acknowledges
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      o_core_ack <= 1'b0;
      o_prog_ack <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take && (act_op == OP_READ) && is_mem && t_impl && rd_ok) begin
            state_reg <= ST_READ;
          end else if (take) begin
            state_reg <= ST_DONE;
            o_core_ack <= !sel_prog;
            o_prog_ack <= sel_prog;
          end
        end
        ST_READ: begin
          state_reg <= ST_DONE;
          o_core_ack <= !sel_prog_reg;
          o_prog_ack <= sel_prog_reg;
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
          o_core_ack <= 1'b0;
          o_prog_ack <= 1'b0;
        end
      endcase
    end
  end

  // remembers the owner of a memory read in flight
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_prog_reg <= 1'b0;
    end else if (take) begin
      sel_prog_reg <= sel_prog;
    end
  end

  // ----------------------------------------
  // answer data and refusal flag
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `PBP_ZERO_BYTE;
      o_refused <= 1'b0;
    end else if (state_reg == ST_READ) begin
      o_rdata <= i_mem_rdata;
      o_refused <= 1'b0;
    end else if (take) begin
      o_rdata <= (act_op == OP_READ) ? rd_byte : `PBP_ZERO_BYTE;
      o_refused <= deny;
    end
  end

  // ----------------------------------------
  // flash port strobes
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_erase_all <= 1'b0;
      o_mem_erase_blk <= 1'b0;
      o_mem_addr <= 22'h000000;
      o_mem_wdata <= `PBP_ZERO_BYTE;
    end else begin
      o_mem_rd <= take && (act_op == OP_READ) && is_mem && t_impl && rd_ok;
      o_mem_wr <= take && (act_op == OP_WRITE) && is_mem && wr_ok;
      o_mem_erase_all <= erase_go && (act_op == OP_ERASE_ALL);
      o_mem_erase_blk <= erase_go && (act_op == OP_ERASE_BLK) && t_impl;
      if (take) begin
        o_mem_addr <= act_addr;
        o_mem_wdata <= act_wdata;
      end
    end
  end

  // ----------------------------------------
  // protection bits
  // ----------------------------------------
  // bits of missing blocks are held by software, logic treats them alike
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rp_reg <= `PBP_PROT_RST;
      wp_reg <= `PBP_PROT_RST;
      trp_reg <= `PBP_PROT_RST;
      cfg_wp_reg <= `PBP_CFGWP_RST;
    end else if (erase_go && (act_op == OP_ERASE_ALL)) begin
      rp_reg <= `PBP_PROT_RST;
      wp_reg <= `PBP_PROT_RST;
      trp_reg <= `PBP_PROT_RST;
      cfg_wp_reg <= `PBP_CFGWP_RST;
    end else if (erase_go && t_impl) begin
      rp_reg[t_blk] <= 1'b1;
      wp_reg[t_blk] <= 1'b1;
      trp_reg[t_blk] <= 1'b1;
    end else if (take && (act_op == OP_WRITE) && is_cfg && cfg_wr_ok) begin
      unique case (act_addr)
        `PBP_CFG_RP_LO: rp_reg <= one_way(rp_reg, {act_wdata[3:0], 1'b1});
        `PBP_CFG_RP_HI: rp_reg <= one_way(rp_reg, {4'hf, act_wdata[`PBP_BOOT_BIT]});
        `PBP_CFG_WP_LO: wp_reg <= one_way(wp_reg, {act_wdata[3:0], 1'b1});
        `PBP_CFG_WP_HI: begin
          wp_reg <= one_way(wp_reg, {4'hf, act_wdata[`PBP_BOOT_BIT]});
          if (sel_prog) begin
            cfg_wp_reg <= act_wdata[`PBP_CFGWP_BIT];
          end
        end
        `PBP_CFG_TRP_LO: trp_reg <= one_way(trp_reg, {act_wdata[3:0], 1'b1});
        `PBP_CFG_TRP_HI: trp_reg <= one_way(trp_reg, {4'hf, act_wdata[`PBP_BOOT_BIT]});
        default: cfg_wp_reg <= cfg_wp_reg;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_boot_map: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (act_addr <= `PBP_BOOT_END) |-> (t_blk == `PBP_BLK_BOOT))
    else $error("boot block address mapped to wrong block");

  a_bits_drop_only: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !erase_go |=> ((rp_reg & ~$past(rp_reg)) == 5'h00) && ((wp_reg & ~$past(wp_reg)) == 5'h00)
      && ((trp_reg & ~$past(trp_reg)) == 5'h00))
    else $error("protection bit rose without an erase");

  a_erase_restore: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (erase_go && (act_op == OP_ERASE_ALL)) |=> (rp_reg == `PBP_PROT_RST) && (wp_reg == `PBP_PROT_RST)
      && (trp_reg == `PBP_PROT_RST) ##1 o_prog_ack == 1'b0)
    else $error("chip erase did not restore protection bits");

  a_core_no_erase: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (take && !sel_prog && (act_op inside {OP_ERASE_ALL, OP_ERASE_BLK}))
      |=> !o_mem_erase_all && !o_mem_erase_blk && o_refused && o_core_ack)
    else $error("erase from running code was accepted");

  a_core_ignores_rp: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (take && !sel_prog && (act_op == OP_READ) && is_mem && t_impl && trp_reg[t_blk])
      |=> o_mem_rd ##1 o_core_ack && (o_rdata == $past(i_mem_rdata)))
    else $error("core read blocked by read-protect");

  a_prog_rp_block: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (take && sel_prog && (act_op inside {OP_READ, OP_WRITE}) && is_mem && t_impl
      && !rp_reg[t_blk]) |=> !o_mem_rd && !o_mem_wr && o_refused && o_prog_ack)
    else $error("programmer reached a read-protected block");

  a_trp_inside: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (take && !sel_prog && (act_op == OP_READ) && is_mem && t_impl && pc_impl
      && (pc_blk == t_blk)) |=> o_mem_rd ##1 o_core_ack && !o_refused)
    else $error("read from inside own block was refused");

  a_trp_outside: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (take && !sel_prog && (act_op == OP_READ) && is_mem && t_impl && !trp_reg[t_blk]
      && !(pc_impl && (pc_blk == t_blk)))
      |=> o_core_ack && o_refused && (o_rdata == `PBP_ZERO_BYTE) && !o_mem_rd)
    else $error("outside table read was not refused");

  a_wp_suppress: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (take && (act_op == OP_WRITE) && is_mem && t_impl && !wp_reg[t_blk])
      |=> !o_mem_wr && o_refused)
    else $error("write reached a write-protected block");

  a_cfg_wp_core: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (take && !sel_prog && !erase_go) |=> (cfg_wp_reg == $past(cfg_wp_reg)))
    else $error("core changed config write-protect");

  a_id_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (take && (act_op == OP_READ) && (act_addr == `PBP_DEVID_LO)) |=> (o_rdata == DEV_ID_LO))
    else $error("identification byte wrong");

  a_unimpl_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (take && (act_op == OP_READ) && is_mem && !t_impl)
      |=> !o_mem_rd && (o_rdata == `PBP_ZERO_BYTE) && !o_refused)
    else $error("unimplemented space did not read zero");
endmodule
`default_nettype wire

/* File: pbp_flash_model.sv */
`default_nettype none
module pbp_flash_model (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic i_mem_erase_all,
  input wire logic i_mem_erase_blk,
  input wire logic [21:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  output logic [7:0] o_mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  logic [7:0] hold_reg;
  // ----------------------------------------
  // contents: written bytes, else an address pattern
  // ----------------------------------------
  function automatic logic [7:0] peek(input logic [21:0] a);
    if (mem.exists(int'(a))) begin
      return mem[int'(a)];
    end
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  // store writes, erase clears the whole array
  always @(posedge i_sys_clk) begin
    if (i_mem_wr) begin
      mem[int'(i_mem_addr)] = i_mem_wdata;
    end
    if (i_mem_erase_all || i_mem_erase_blk) begin
      mem.delete();
    end
  end
  // data stays for one cycle after the strobe, then turns over every cycle
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_reg <= 8'h96;
    end else if (i_mem_rd) begin
      hold_reg <= peek(i_mem_addr);
    end else begin
      hold_reg <= ~hold_reg;
    end
  end
  assign o_mem_rdata = i_mem_rd ? peek(i_mem_addr) : hold_reg;
endmodule
`default_nettype wire

/* File: pbp_prot_top_test.sv */
`include "pbp_defines.svh"
`default_nettype none
module pbp_prot_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pbp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, c_req = 1'b0, p_req = 1'b0;
  pbp_op_type c_op = OP_READ, p_op = OP_READ;
  logic [21:0] c_addr = 22'h0, c_pc = 22'h0, p_addr = 22'h0, m_addr;
  logic [7:0] c_wd = 8'h0, p_wd = 8'h0, m_rdata, m_wd, rdata;
  logic c_ack, p_ack, refused, m_rd, m_wr, m_ea, m_eb;
  logic [7:0] rd_v;
  logic ref_v, s_rd, s_wr, s_er;
  int fails = 0, checks_done = 0, cycles = 0;
  logic [7:0] masks [6] = '{8'h0f, 8'h40, 8'h0f, 8'h60, 8'h0f, 8'h40};
  // ----------------------------------------
  // design, flash model, clock
  // ----------------------------------------
  pbp_prot_top dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_core_req(c_req), .i_core_op(c_op),
    .i_core_addr(c_addr), .i_core_pc(c_pc), .i_core_wdata(c_wd), .i_prog_req(p_req),
    .i_prog_op(p_op), .i_prog_addr(p_addr), .i_prog_wdata(p_wd), .i_mem_rdata(m_rdata),
    .o_core_ack(c_ack), .o_prog_ack(p_ack), .o_rdata(rdata), .o_refused(refused),
    .o_mem_rd(m_rd), .o_mem_wr(m_wr), .o_mem_erase_all(m_ea), .o_mem_erase_blk(m_eb),
    .o_mem_addr(m_addr), .o_mem_wdata(m_wd));
  pbp_flash_model flash_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_mem_rd(m_rd),
    .i_mem_wr(m_wr), .i_mem_erase_all(m_ea), .i_mem_erase_blk(m_eb), .i_mem_addr(m_addr),
    .i_mem_wdata(m_wd), .o_mem_rdata(m_rdata));
  always #50 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [7:0] pat(input logic [21:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one request, held until its ack, strobes collected on the way
  task automatic xfer(input logic prog, input pbp_op_type op, input logic [21:0] a,
                      input logic [21:0] pc, input logic [7:0] wd);
    logic ack;
    @(negedge clk);
    s_rd = 1'b0;
    s_wr = 1'b0;
    s_er = 1'b0;
    if (prog) begin
      p_req = 1'b1; p_op = op; p_addr = a; p_wd = wd;
    end else begin
      c_req = 1'b1; c_op = op; c_addr = a; c_pc = pc; c_wd = wd;
    end
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      s_rd = s_rd | m_rd;
      s_wr = s_wr | m_wr;
      s_er = s_er | m_ea | m_eb;
      ack = prog ? p_ack : c_ack;
      if (ack === 1'b1) break;
    end
    chk({7'h0, ack}, 8'h01, "ack");
    rd_v = rdata;
    ref_v = refused;
    p_req = 1'b0;
    c_req = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_expect(input logic prog, input logic [21:0] a, input logic [21:0] pc,
                           input logic [7:0] exp, input logic rf, input string what);
    xfer(prog, OP_READ, a, pc, 8'h00);
    chk(rd_v, exp, what);
    chk({7'h0, ref_v}, {7'h0, rf}, what);
  endtask
  task automatic cfg_bits(input int i, input logic [7:0] exp);
    xfer(1'b0, OP_READ, `PBP_CFG_RP_LO + 22'(i), 22'h000100, 8'h00);
    chk(rd_v & masks[i], exp, "config bits");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_vals;
    for (int i = 0; i < 6; i++) cfg_bits(i, masks[i]);
    rd_expect(1'b0, `PBP_DEVID_LO, 22'h000100, 8'h5a, 1'b0, "id low");
    rd_expect(1'b0, `PBP_DEVID_HI, 22'h000100, 8'ha5, 1'b0, "id high");
  endtask
  task automatic t_plain_read;
    rd_expect(1'b0, 22'h004010, 22'h000100, pat(22'h004010), 1'b0, "core read");
    chk({7'h0, s_rd}, 8'h01, "flash read strobe");
    rd_expect(1'b0, 22'h010000, 22'h000100, 8'h00, 1'b0, "unimplemented");
    chk({7'h0, s_rd}, 8'h00, "no strobe above top");
  endtask
  task automatic t_table_read;
    xfer(1'b0, OP_WRITE, `PBP_CFG_TRP_LO, 22'h000100, 8'hfd);
    rd_expect(1'b0, 22'h004000, 22'h003fff, 8'h00, 1'b1, "outside block");
    rd_expect(1'b0, 22'h004000, 22'h004000, pat(22'h004000), 1'b0, "inside");
    xfer(1'b0, OP_WRITE, `PBP_CFG_TRP_HI, 22'h000100, 8'hbf);
    rd_expect(1'b0, 22'h0007ff, 22'h000800, 8'h00, 1'b1, "boot outside");
    rd_expect(1'b0, 22'h0007ff, 22'h0007ff, pat(22'h0007ff), 1'b0, "boot in");
  endtask
  task automatic t_one_way;
    xfer(1'b0, OP_WRITE, `PBP_CFG_TRP_LO, 22'h000100, 8'hff);
    cfg_bits(4, 8'h0d);
    xfer(1'b0, OP_ERASE_BLK, 22'h004000, 22'h000100, 8'h00);
    chk({6'h0, ref_v, s_er}, 8'h02, "core erase");
    cfg_bits(4, 8'h0d);
  endtask
  task automatic t_erase_blk;
    xfer(1'b1, OP_ERASE_BLK, 22'h004000, 22'h0, 8'h00);
    chk({6'h0, ref_v, s_er}, 8'h01, "programmer erase");
    cfg_bits(4, 8'h0f);
    cfg_bits(5, 8'h00);
  endtask
  task automatic t_read_prot;
    xfer(1'b1, OP_WRITE, `PBP_CFG_RP_LO, 22'h0, 8'hfb);
    rd_expect(1'b1, 22'h008000, 22'h0, 8'h00, 1'b1, "programmer read");
    chk({7'h0, s_rd}, 8'h00, "no read strobe");
    rd_expect(1'b0, 22'h008000, 22'h008000, pat(22'h008000), 1'b0, "core read");
  endtask
  task automatic t_write_prot;
    xfer(1'b0, OP_WRITE, `PBP_CFG_WP_LO, 22'h000100, 8'hf7);
    xfer(1'b0, OP_WRITE, 22'h00c000, 22'h000100, 8'h11);
    chk({6'h0, ref_v, s_wr}, 8'h02, "protected write");
    xfer(1'b0, OP_WRITE, 22'h00bfff, 22'h000100, 8'h22);
    chk({6'h0, ref_v, s_wr}, 8'h01, "open write");
    rd_expect(1'b0, 22'h00bfff, 22'h000100, 8'h22, 1'b0, "write back");
  endtask
  task automatic t_cfg_wp;
    xfer(1'b0, OP_WRITE, `PBP_CFG_WP_HI, 22'h000100, 8'hdf);
    cfg_bits(3, 8'h60);
    xfer(1'b1, OP_WRITE, `PBP_CFG_WP_HI, 22'h0, 8'hdf);
    cfg_bits(3, 8'h40);
    xfer(1'b0, OP_WRITE, `PBP_CFG_TRP_LO, 22'h000100, 8'hfe);
    chk({7'h0, ref_v}, 8'h01, "locked config");
    xfer(1'b1, OP_ERASE_ALL, 22'h0, 22'h0, 8'h00);
    chk({7'h0, s_er}, 8'h01, "chip erase");
    for (int i = 0; i < 6; i++) cfg_bits(i, masks[i]);
  endtask
  // ----------------------------------------
  // main sequence and verdict
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_reset_vals();
    t_plain_read();
    t_table_read();
    t_one_way();
    t_erase_blk();
    t_read_prot();
    t_write_prot();
    t_cfg_wp();
    final_report();
  end
endmodule
`default_nettype wire
